// ---- pkg/pcr_pkg.sv ----
// constants and carrier types for the profiler configuration registers
package pcr_pkg;

  // model-specific register addresses
  localparam logic [31:0] PCR_CBADDR_MSR = 32'hc0000106;
  localparam logic [31:0] PCR_CFG_MSR = 32'hc0000105;

  // reset values
  localparam logic [63:0] PCR_CFG_RESET = 64'h0000000000000000;
  localparam logic [63:0] PCR_CBADDR_RESET = 64'h0000000000000000;

  // configuration word field positions
  localparam int PCR_CFG_VAL_BIT = 1;
  localparam int PCR_CFG_EVT_LO = 2;
  localparam int PCR_CFG_WRAP_BIT = 29;
  localparam int PCR_CFG_TS_BIT = 30;
  localparam int PCR_CFG_INT_BIT = 31;
  localparam int PCR_CFG_CORE_LO = 32;
  localparam int PCR_CFG_CORE_HI = 39;
  localparam int PCR_CFG_VEC_LO = 40;
  localparam int PCR_CFG_VEC_HI = 47;
  // writable bits: 1..6, 29..47
  localparam logic [63:0] PCR_CFG_WMASK = 64'h0000ffffe000007e;

  // feature availability bit in the extended-state enable mask
  localparam int PCR_XMASK_BIT = 62;

  // counter layout: index 0 is the value sample, 1..5 hardware events
  localparam int PCR_NUM_CNT = 6;
  localparam int PCR_NUM_HW_EVT = 5;

  // event identifiers written into records
  localparam logic [7:0] PCR_ID_VALUE = 8'h01;
  localparam logic [7:0] PCR_ID_EVT_BASE = 8'h01;
  localparam logic [7:0] PCR_ID_INSERT = 8'hff;

  // default sampling interval, counts of ticks minus one
  localparam int PCR_CNT_W = 16;
  localparam int PCR_INTERVAL_DEF = 0;

  typedef enum logic [1:0] {
    PCR_OP_LOAD,
    PCR_OP_STORE,
    PCR_OP_INSERT,
    PCR_OP_VALUE
  } pcr_op_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [63:0] data;
  } pcr_msr_req_t;

  typedef struct packed {
    logic valid;
    pcr_op_t op;
    logic [63:0] operand;
  } pcr_instr_req_t;

  typedef struct packed {
    logic [7:0] eventId;
    logic [7:0] coreTag;
    logic [63:0] timestamp;
    logic [63:0] data;
  } pcr_record_t;

endpackage : pcr_pkg

// ---- hw/pcr_event_counter.sv ----
// sampling counter that raises a sticky fire flag every INTERVAL+1 ticks
`timescale 1ns/10ps
module pcr_event_counter #(
  parameter int W = 16,
  parameter int INTERVAL = 0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic tick,
  input wire logic grant,
  output logic fire
);
  import pcr_pkg::*;

  localparam logic [W-1:0] RELOAD = W'(INTERVAL);

  logic [W-1:0] cnt_reg;
  logic fire_reg;

  initial
  begin
    if (W < 1 || INTERVAL < 0 || INTERVAL >= (2 ** W))
      $error("interval does not fit the counter width");
  end

  // counter decrements per tick, fires past zero and reloads
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= '0;
    else if (clear)
      cnt_reg <= RELOAD;
    else if (tick)
      cnt_reg <= (cnt_reg == '0) ? RELOAD : cnt_reg - W'(1);
  end

  // set wins over grant
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      fire_reg <= 1'b0;
    else if (clear)
      fire_reg <= 1'b0;
    else if (tick && cnt_reg == '0)
      fire_reg <= 1'b1;
    else if (grant)
      fire_reg <= 1'b0;
  end

  assign fire = fire_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_fire_at_zero;
    tick && !clear && cnt_reg == '0 |=> fire && cnt_reg == RELOAD;
  endproperty
  a_fire_at_zero: assert property (p_fire_at_zero) else $error("counter did not fire at zero");

  property p_no_early_fire;
    tick && !clear && cnt_reg != '0 && !fire && !grant |=> !fire;
  endproperty
  a_no_early_fire: assert property (p_no_early_fire) else $error("counter fired before interval");

endmodule : pcr_event_counter

// ---- hw/pcr_config_regs.sv ----
// profiler configuration and control-block address registers with instruction gating
`timescale 1ns/10ps
module pcr_config_regs #(
  parameter int CNT_W = pcr_pkg::PCR_CNT_W,
  parameter int INTERVAL = pcr_pkg::PCR_INTERVAL_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input pcr_pkg::pcr_msr_req_t msrReq,
  output logic msrAck,
  output logic [63:0] msrRdata,
  output logic msrGpFault,
  input wire logic profilerSupported,
  input wire logic [63:0] extStateEnableMask,
  input wire logic [63:0] dsBase,
  input pcr_pkg::pcr_instr_req_t instrReq,
  output logic instrDone,
  output logic instrUdFault,
  output logic [63:0] instrResult,
  input wire logic [4:0] eventPulse,
  input wire logic [63:0] timestampCounter,
  input wire logic timestampPresent,
  input wire logic thresholdCrossed,
  output logic recordValid,
  output pcr_pkg::pcr_record_t record,
  output logic thresholdIrq,
  output logic [7:0] irqVector,
  output logic wraparoundMode,
  output logic profilerActive,
  output logic [63:0] ctrlBlockLinearAddr
);
  import pcr_pkg::*;

  initial
  begin
    if (PCR_NUM_HW_EVT != 5 || PCR_NUM_CNT != PCR_NUM_HW_EVT + 1)
      $error("counter layout does not match event inputs");
  end

  logic [63:0] cfgReg;
  logic [63:0] cbaddrReg;
  logic activeReg;
  logic [63:0] valueDataReg;
  logic msrAckReg;
  logic [63:0] msrRdataReg;
  logic msrGpReg;
  logic instrDoneReg;
  logic instrUdReg;
  logic [63:0] instrResultReg;
  logic recordValidReg;
  pcr_record_t recordReg;
  logic irqReg;
  logic [7:0] irqVectorReg;
  logic wrapReg;

  logic msrWrCfg;
  logic msrRdCfg;
  logic msrWrCb;
  logic msrRdCb;
  logic msrUnmapped;
  logic stopWrite;
  logic available;
  logic instrOk;
  logic doLoad;
  logic doInsert;
  logic valueTick;
  logic clearCnt;
  logic [PCR_NUM_CNT-1:0] fires;
  logic [PCR_NUM_CNT-1:0] ticks;
  logic [PCR_NUM_CNT-1:0] grants;
  logic [7:0] grantId;
  logic grantAny;
  logic [63:0] stampNow;

  // register decode
  assign msrWrCfg = msrReq.valid && msrReq.write && msrReq.addr == PCR_CFG_MSR;
  assign msrRdCfg = msrReq.valid && !msrReq.write && msrReq.addr == PCR_CFG_MSR;
  assign msrWrCb = msrReq.valid && msrReq.write && msrReq.addr == PCR_CBADDR_MSR;
  assign msrRdCb = msrReq.valid && !msrReq.write && msrReq.addr == PCR_CBADDR_MSR;
  assign msrUnmapped = msrReq.valid && msrReq.addr != PCR_CFG_MSR && msrReq.addr != PCR_CBADDR_MSR;
  assign stopWrite = msrWrCb && msrReq.data == 64'h0000000000000000;

  // instruction gating
  assign available = profilerSupported && extStateEnableMask[PCR_XMASK_BIT];
  assign instrOk = instrReq.valid && available;
  assign doLoad = instrOk && instrReq.op == PCR_OP_LOAD && !stopWrite;
  assign doInsert = instrOk && instrReq.op == PCR_OP_INSERT && activeReg;
  assign valueTick = instrOk && instrReq.op == PCR_OP_VALUE && activeReg && cfgReg[PCR_CFG_VAL_BIT];
  assign clearCnt = stopWrite || doLoad;

  // configuration word, reserved bits held at zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cfgReg <= PCR_CFG_RESET;
    else if (msrWrCfg)
      cfgReg <= msrReq.data & PCR_CFG_WMASK;
  end

  // control-block linear address and profiling state
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cbaddrReg <= PCR_CBADDR_RESET;
      activeReg <= 1'b0;
    end
    else if (stopWrite)
    begin
      cbaddrReg <= PCR_CBADDR_RESET;
      activeReg <= 1'b0;
    end
    else if (doLoad)
    begin
      if (instrReq.operand == 64'h0000000000000000)
      begin
        cbaddrReg <= PCR_CBADDR_RESET;
        activeReg <= 1'b0;
      end
      else
      begin
        cbaddrReg <= instrReq.operand + dsBase;
        activeReg <= 1'b1;
      end
    end
  end

  // register read and write answers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      msrAckReg <= 1'b0;
      msrRdataReg <= 64'h0000000000000000;
      msrGpReg <= 1'b0;
    end
    else
    begin
      msrAckReg <= msrReq.valid;
      msrGpReg <= msrUnmapped || (msrWrCb && !stopWrite);
      if (msrRdCfg)
        msrRdataReg <= cfgReg;
      else if (msrRdCb)
        msrRdataReg <= cbaddrReg;
      else
        msrRdataReg <= 64'h0000000000000000;
    end
  end

  // instruction completion
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      instrDoneReg <= 1'b0;
      instrUdReg <= 1'b0;
      instrResultReg <= 64'h0000000000000000;
    end
    else
    begin
      instrDoneReg <= instrReq.valid;
      instrUdReg <= instrReq.valid && !available;
      if (instrOk && instrReq.op == PCR_OP_STORE)
        instrResultReg <= activeReg ? cbaddrReg - dsBase : 64'h0000000000000000;
      else
        instrResultReg <= 64'h0000000000000000;
    end
  end

  // operand held for the value-sample record
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      valueDataReg <= 64'h0000000000000000;
    else if (valueTick)
      valueDataReg <= instrReq.operand;
  end

  // sampling counters
  assign ticks[0] = valueTick;
  genvar gi;
  generate
    for (gi = 1; gi < PCR_NUM_CNT; gi++)
    begin : g_evt
      assign ticks[gi] = eventPulse[gi-1] && activeReg && cfgReg[PCR_CFG_EVT_LO+gi-1];
    end
    for (gi = 0; gi < PCR_NUM_CNT; gi++)
    begin : g_cnt
      pcr_event_counter #(
        .W(CNT_W),
        .INTERVAL(INTERVAL)
      ) u_cnt (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clear(clearCnt),
        .tick(ticks[gi]),
        .grant(grants[gi]),
        .fire(fires[gi])
      );
    end
  endgenerate

  // insert has priority, then lowest counter index
  always_comb
  begin
    grants = '0;
    grantAny = 1'b0;
    grantId = PCR_ID_VALUE;
    if (!doInsert && activeReg && !clearCnt)
    begin
      for (int i = PCR_NUM_CNT - 1; i >= 0; i--)
      begin
        if (fires[i])
        begin
          grants = '0;
          grants[i] = 1'b1;
          grantAny = 1'b1;
          grantId = (i == 0) ? PCR_ID_VALUE : PCR_ID_EVT_BASE + 8'(i);
        end
      end
    end
  end

  assign stampNow = (cfgReg[PCR_CFG_TS_BIT] && timestampPresent) ? timestampCounter : 64'h0000000000000000;

  // event record output
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      recordValidReg <= 1'b0;
      recordReg <= '0;
    end
    else
    begin
      recordValidReg <= doInsert || grantAny;
      recordReg.coreTag <= cfgReg[PCR_CFG_CORE_HI:PCR_CFG_CORE_LO];
      recordReg.timestamp <= stampNow;
      if (doInsert)
      begin
        recordReg.eventId <= PCR_ID_INSERT;
        recordReg.data <= instrReq.operand;
      end
      else
      begin
        recordReg.eventId <= grantId;
        recordReg.data <= grants[0] ? valueDataReg : 64'h0000000000000000;
      end
    end
  end

  // threshold interrupt and mode
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqReg <= 1'b0;
      irqVectorReg <= 8'h00;
      wrapReg <= 1'b0;
    end
    else
    begin
      irqReg <= thresholdCrossed && activeReg && cfgReg[PCR_CFG_INT_BIT];
      irqVectorReg <= cfgReg[PCR_CFG_VEC_HI:PCR_CFG_VEC_LO];
      wrapReg <= cfgReg[PCR_CFG_WRAP_BIT];
    end
  end

  assign msrAck = msrAckReg;
  assign msrRdata = msrRdataReg;
  assign msrGpFault = msrGpReg;
  assign instrDone = instrDoneReg;
  assign instrUdFault = instrUdReg;
  assign instrResult = instrResultReg;
  assign recordValid = recordValidReg;
  assign record = recordReg;
  assign thresholdIrq = irqReg;
  assign irqVector = irqVectorReg;
  assign wraparoundMode = wrapReg;
  assign profilerActive = activeReg;
  assign ctrlBlockLinearAddr = cbaddrReg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_wrap;
    msrWrCfg |-> ##2 wraparoundMode == $past(msrReq.data[PCR_CFG_WRAP_BIT], 2);
  endproperty
  a_wrap: assert property (p_wrap) else $error("mode does not follow wraparound bit");

  property p_stamp;
    recordValid && record.timestamp != 64'h0000000000000000 |-> $past(cfgReg[PCR_CFG_TS_BIT] && timestampPresent);
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp stored while disabled");

  property p_irq;
    thresholdIrq |-> $past(cfgReg[PCR_CFG_INT_BIT] && activeReg && thresholdCrossed);
  endproperty
  a_irq: assert property (p_irq) else $error("threshold interrupt without allow bit");

  property p_core;
    recordValid |-> record.coreTag == $past(cfgReg[PCR_CFG_CORE_HI:PCR_CFG_CORE_LO]);
  endproperty
  a_core: assert property (p_core) else $error("record core tag mismatch");

  property p_vec;
    thresholdIrq |-> irqVector == $past(cfgReg[PCR_CFG_VEC_HI:PCR_CFG_VEC_LO]);
  endproperty
  a_vec: assert property (p_vec) else $error("interrupt vector mismatch");

  property p_cbread;
    msrRdCb && !instrReq.valid |=> msrAck && !msrGpFault && msrRdata == $past(cbaddrReg) && $stable(cbaddrReg);
  endproperty
  a_cbread: assert property (p_cbread) else $error("address read wrong or had side effects");

  property p_nonzero;
    msrWrCb && msrReq.data != 64'h0000000000000000 && !instrReq.valid |=> msrGpFault && $stable(cbaddrReg);
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("nonzero address write not refused");

  property p_stop;
    stopWrite |=> !profilerActive && cbaddrReg == 64'h0000000000000000 && fires == '0 ##1 !recordValid;
  endproperty
  a_stop: assert property (p_stop) else $error("zero write did not stop profiling");

  property p_ud;
    instrReq.valid && !available |=> instrDone && instrUdFault && !(recordValid && record.eventId == PCR_ID_INSERT);
  endproperty
  a_ud: assert property (p_ud) else $error("unavailable instruction not faulted");

  property p_insert;
    doInsert |=> recordValid && record.eventId == PCR_ID_INSERT;
  endproperty
  a_insert: assert property (p_insert) else $error("insert did not store a record");

  property p_rsvd;
    msrRdCfg |=> (msrRdata & ~PCR_CFG_WMASK) == 64'h0000000000000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved config bits read nonzero");

  c_insert: cover property (doInsert ##1 recordValid);
  c_value: cover property (valueTick ##[1:4] (recordValid && record.eventId == PCR_ID_VALUE));
  c_stop: cover property (activeReg ##1 stopWrite);
  c_irq: cover property (thresholdIrq);

endmodule : pcr_config_regs

// ---- testbench/pcr_config_regs_bench.sv ----
// self-checking bench for the profiler configuration registers
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
module pcr_config_regs_bench;
  import pcr_pkg::*;
  localparam int IVL = 2;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  pcr_msr_req_t msrReq = '0;
  pcr_instr_req_t instrReq = '0;
  logic profilerSupported = 1'b1;
  logic [63:0] extStateEnableMask = 64'h4000000000000000;
  logic [63:0] dsBase = 64'h0;
  logic [4:0] eventPulse = 5'h0;
  logic [63:0] timestampCounter = 64'h1234;
  logic timestampPresent = 1'b1;
  logic thresholdCrossed = 1'b0;
  logic msrAck, msrGpFault, instrDone, instrUdFault, recordValid, thresholdIrq, wraparoundMode, profilerActive;
  logic [63:0] msrRdata, instrResult, ctrlBlockLinearAddr;
  logic [7:0] irqVector;
  pcr_record_t record;
  logic ack, gp, done, ud, recV;
  logic [63:0] rd, res;
  pcr_record_t rec;
  int n_errors = 0;
  int checked = 0;
  int recCount = 0;
  logic [7:0] lastId;
  logic [63:0] lastData;
  always #2.5 ref_clk = ~ref_clk;
  pcr_config_regs #(.INTERVAL(IVL)) pcr_config_regs_inst (.ref_clk(ref_clk), .rstn(rstn), .msrReq(msrReq),
    .msrAck(msrAck), .msrRdata(msrRdata), .msrGpFault(msrGpFault), .profilerSupported(profilerSupported),
    .extStateEnableMask(extStateEnableMask), .dsBase(dsBase), .instrReq(instrReq), .instrDone(instrDone),
    .instrUdFault(instrUdFault), .instrResult(instrResult), .eventPulse(eventPulse),
    .timestampCounter(timestampCounter), .timestampPresent(timestampPresent), .thresholdCrossed(thresholdCrossed),
    .recordValid(recordValid), .record(record), .thresholdIrq(thresholdIrq), .irqVector(irqVector),
    .wraparoundMode(wraparoundMode), .profilerActive(profilerActive), .ctrlBlockLinearAddr(ctrlBlockLinearAddr));
  always @(posedge ref_clk)
  begin
    if (recordValid === 1'b1)
    begin
      recCount <= recCount + 1;
      lastId <= record.eventId;
      lastData <= record.data;
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic msr(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(posedge ref_clk) msrReq <= {1'b1, w, a, d};
    @(posedge ref_clk) msrReq <= '0;
    #1;
    ack = msrAck;
    rd = msrRdata;
    gp = msrGpFault;
    `CHK("msrAck", 1'b1, ack);
  endtask : msr
  task automatic instr(input pcr_op_t op, input logic [63:0] v);
    @(posedge ref_clk) instrReq <= {1'b1, op, v};
    @(posedge ref_clk) instrReq <= '0;
    #1;
    done = instrDone;
    ud = instrUdFault;
    res = instrResult;
    recV = recordValid;
    rec = record;
    `CHK("instrDone", 1'b1, done);
  endtask : instr
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic t_reset;
    `CHK("active", 1'b0, profilerActive);
    msr(1'b0, PCR_CBADDR_MSR, 64'h0);
    `CHK("cbaddr", PCR_CBADDR_RESET, rd);
    msr(1'b0, PCR_CFG_MSR, 64'h0);
    `CHK("cfg", PCR_CFG_RESET, rd);
  endtask : t_reset
  task automatic t_cfg;
    msr(1'b1, PCR_CFG_MSR, 64'hffffffffffffffff);
    msr(1'b0, PCR_CFG_MSR, 64'h0);
    `CHK("cfg", PCR_CFG_WMASK, rd);
    `CHK("wrap", 1'b1, wraparoundMode);
    `CHK("vector", 8'hff, irqVector);
    msr(1'b1, PCR_CFG_MSR, 64'h0);
    idle(1);
    `CHK("wrap", 1'b0, wraparoundMode);
  endtask : t_cfg
  task automatic t_gate;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk) profilerSupported <= (k != 0);
      extStateEnableMask <= (k == 1) ? 64'hbfffffffffffffff : 64'h4000000000000000;
      for (int o = 0; o < 4; o++)
      begin
        instr(pcr_op_t'(o), 64'h0);
        `CHK("ud", (k != 2), ud);
      end
    end
    `CHK("active", 1'b0, profilerActive);
  endtask : t_gate
  task automatic t_load;
    @(posedge ref_clk) dsBase <= 64'h100;
    instr(PCR_OP_LOAD, 64'h1000);
    `CHK("active", 1'b1, profilerActive);
    `CHK("linear", 64'h1100, ctrlBlockLinearAddr);
    instr(PCR_OP_STORE, 64'h0);
    `CHK("store", 64'h1000, res);
    msr(1'b0, PCR_CBADDR_MSR, 64'h0);
    `CHK("cbaddr", 64'h1100, rd);
    `CHK("active", 1'b1, profilerActive);
    @(posedge ref_clk) dsBase <= 64'h200;
    instr(PCR_OP_STORE, 64'h0);
    `CHK("store", 64'hf00, res);
    `CHK("linear", 64'h1100, ctrlBlockLinearAddr);
    msr(1'b1, PCR_CBADDR_MSR, 64'h5);
    `CHK("gp", 1'b1, gp);
    msr(1'b0, PCR_CBADDR_MSR, 64'h0);
    `CHK("cbaddr", 64'h1100, rd);
    `CHK("gp", 1'b0, gp);
    msr(1'b0, 32'hc0000107, 64'h0);
    `CHK("gp", 1'b1, gp);
  endtask : t_load
  task automatic t_insert;
    msr(1'b1, PCR_CFG_MSR, 64'h0000005a40000000);
    instr(PCR_OP_INSERT, 64'hbeef);
    `CHK("recV", 1'b1, recV);
    `CHK("id", PCR_ID_INSERT, rec.eventId);
    `CHK("data", 64'hbeef, rec.data);
    `CHK("tag", 8'h5a, rec.coreTag);
    `CHK("ts", 64'h1234, rec.timestamp);
    @(posedge ref_clk) timestampPresent <= 1'b0;
    instr(PCR_OP_INSERT, 64'h7);
    `CHK("recV", 1'b1, recV);
    `CHK("ts", 64'h0, rec.timestamp);
  endtask : t_insert
  task automatic pulse_thr(input logic exp);
    @(posedge ref_clk) thresholdCrossed <= 1'b1;
    @(posedge ref_clk) thresholdCrossed <= 1'b0;
    #1;
    `CHK("irq", exp, thresholdIrq);
  endtask : pulse_thr
  task automatic t_thr;
    pulse_thr(1'b0);
    msr(1'b1, PCR_CFG_MSR, 64'h0000210080000000);
    idle(1);
    `CHK("vector", 8'h21, irqVector);
    pulse_thr(1'b1);
  endtask : t_thr
  task automatic t_sample;
    msr(1'b1, PCR_CFG_MSR, 64'h0000000000000004);
    recCount = 0;
    repeat (IVL + 1) instr(PCR_OP_VALUE, 64'h9);
    idle(4);
    `CHK("records", 0, recCount);
    repeat (IVL + 1)
    begin
      @(posedge ref_clk) eventPulse <= 5'h01;
      @(posedge ref_clk) eventPulse <= 5'h00;
    end
    idle(4);
    `CHK("records", 1, recCount);
    `CHK("id", PCR_ID_EVT_BASE + 8'h01, lastId);
    msr(1'b1, PCR_CFG_MSR, 64'h0000000000000002);
    recCount = 0;
    repeat (IVL) instr(PCR_OP_VALUE, 64'h3c);
    idle(4);
    `CHK("records", 0, recCount);
    instr(PCR_OP_VALUE, 64'h3d);
    idle(4);
    `CHK("records", 1, recCount);
    `CHK("id", PCR_ID_VALUE, lastId);
    `CHK("data", 64'h3d, lastData);
  endtask : t_sample
  task automatic t_stop;
    msr(1'b1, PCR_CBADDR_MSR, 64'h0);
    `CHK("gp", 1'b0, gp);
    `CHK("active", 1'b0, profilerActive);
    `CHK("linear", 64'h0, ctrlBlockLinearAddr);
    instr(PCR_OP_STORE, 64'h0);
    `CHK("store", 64'h0, res);
    recCount = 0;
    instr(PCR_OP_INSERT, 64'h1);
    idle(2);
    `CHK("records", 0, recCount);
  endtask : t_stop
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    idle(1);
    t_reset();
    t_cfg();
    t_gate();
    t_load();
    t_insert();
    t_thr();
    t_sample();
    t_stop();
    tally_and_finish();
  end
endmodule : pcr_config_regs_bench
